// ===== verif/stmr_pins.sv
// partner model: sources for the trigger, capture and overvoltage pins
`timescale 1ns/100ps
module stmr_pins
(
  // clock
  input  wire logic clk_in,
  // pin levels toward the timer
  output logic      trig_out,
  output logic      cap_out,
  output logic      ovp_out
);
  // ==========================================================
  // sources drive all the time, so no pin floats
  initial
  begin
    trig_out = 1'b0;
    cap_out  = 1'b0;
    ovp_out  = 1'b0;
  end

  // one high pulse of hold cycles; sel 0 trigger, 1 capture, 2 overvoltage
  task automatic pulse(input int sel, input int hold);
    @(posedge clk_in);
    case (sel)
      0:       trig_out <= 1'b1;
      1:       cap_out  <= 1'b1;
      default: ovp_out  <= 1'b1;
    endcase
    repeat (hold) @(posedge clk_in);
    trig_out <= 1'b0;
    cap_out  <= 1'b0;
    ovp_out  <= 1'b0;
  endtask
endmodule

// ===== verif/stmr_timer_chk.sv
// checker: port level assertions for the standard timer top
`timescale 1ns/100ps
module stmr_timer_chk
  import stmr_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // ahb-lite slave
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // timer outputs
  input wire logic        timer_out,
  input wire logic        timer_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================================
  // shadow of the written settings, rebuilt from bus writes
  logic        wpend_q;  // write data phase now
  logic [7:0]  wadr_q;   // its offset
  stmr_ctl_s   ctl_q;    // control word
  logic [9:0]  a_q;      // compare_a_value as written
  logic [2:0]  p_q;      // compare_p_value
  logic [3:0]  age_q;    // cycles since a write, saturating
  logic [10:0] gap_q;    // cycles since last irq
  logic        seen_q;   // irq seen with settled settings
  wire logic        take_w = hsel_in & hready_in & htrans_in[1] & hwrite_in;
  // a few cycles of settling hide the sync and output register delay
  wire logic        cfg_w  = age_q >= 4'h4;
  wire logic [10:0] scl_w  = (p_q == STMR_P_ZERO) ? STMR_P_FULL : {1'b0, p_q, 7'h00};
  wire logic [10:0] per_w  = ctl_q.swap ? {1'b0, a_q} + 11'h001 : scl_w;
  wire logic [10:0] dty_w  = ctl_q.swap ? scl_w : {1'b0, a_q};
  wire logic        md2_w  = cfg_w & ctl_q.mode == STMR_MODE_PWM;
  wire logic        pwm_w  = md2_w & ctl_q.pin != STMR_PIN_11;
  wire logic        pls_w  = md2_w & ctl_q.pin == STMR_PIN_11;
  wire logic        cap_w  = cfg_w & ctl_q.mode == STMR_MODE_CAP;
  wire logic        act_w  = ctl_q.init ^ ctl_q.pol;  // active level seen on the pin

  // write tracking; the address phase is one cycle ahead of the data
  always_ff @(posedge clk_in)
  begin
    wpend_q <= ~rst_in & take_w;
    wadr_q  <= haddr_in[7:0];
    age_q   <= (rst_in | wpend_q) ? 4'h0 : age_q + {3'h0, ~&age_q};
  end

  // shadow registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in | wpend_q & wadr_q == STMR_OFF_CTRL)
      ctl_q <= stmr_ctl_s'(rst_in ? 11'h000 : hwdata_in[10:0]);
    if (rst_in | wpend_q & wadr_q == STMR_OFF_CMPA)
      a_q <= rst_in ? 10'h000 : hwdata_in[9:0];
    if (rst_in | wpend_q & wadr_q == STMR_OFF_CMPP)
      p_q <= rst_in ? 3'h0 : hwdata_in[2:0];
  end

  // distance between interrupt pulses
  always_ff @(posedge clk_in)
  begin
    gap_q  <= timer_irq_out ? 11'h001 : gap_q + {10'h000, ~&gap_q};
    seen_q <= cfg_w & ~rst_in & (seen_q | timer_irq_out);
  end

  // ==========================================================
  // pulse ends: output back to idle shortly after the irq
  sequence s_pulse_idle;
    ##[1:3] timer_out != act_w;
  endsequence
  sequence s_irq_quiet;
    !timer_irq_out [*4];
  endsequence

  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("slave stalled or gave an error");
  a_reset_idle: assert property (disable iff (1'b0) rst_in |=> !timer_out && !timer_irq_out)
    else $error("output or irq active after reset");
  a_forced_low: assert property (pwm_w && ctl_q.pin == STMR_PIN_00 |-> !timer_out)
    else $error("pin 00 not forced low");
  a_forced_high: assert property (pwm_w && ctl_q.pin == STMR_PIN_01 |-> timer_out)
    else $error("pin 01 not forced high");
  a_full_duty: assert property (pwm_w && ctl_q.pin == STMR_PIN_10 && ctl_q.run
    && dty_w >= per_w |-> timer_out == act_w)
    else $error("duty at least period not full");
  a_zero_duty: assert property (pwm_w && ctl_q.pin == STMR_PIN_10 && ctl_q.run
    && !ctl_q.swap && dty_w == 11'h000 |-> timer_out != act_w)
    else $error("zero duty wrong level");
  a_pulse_end: assert property (pls_w && timer_irq_out |-> s_pulse_idle)
    else $error("pulse irq without trailing edge");
  a_pulse_once: assert property (pls_w && timer_irq_out |=> s_irq_quiet)
    else $error("pulse irq repeated");
  a_cap_quiet: assert property (cap_w |-> $stable(timer_out))
    else $error("output moved in capture mode");
  a_cap_period: assert property (cap_w && ctl_q.pin == STMR_PIN_11 && ctl_q.run
    && p_q != STMR_P_ZERO && seen_q && timer_irq_out |-> gap_q == scl_w)
    else $error("p match spacing wrong");
endmodule

bind stmr_timer stmr_timer_chk u_chk
(
  .clk_in        (clk_in),
  .rst_in        (rst_in),
  .hsel_in       (hsel_in),
  .haddr_in      (haddr_in),
  .htrans_in     (htrans_in),
  .hwrite_in     (hwrite_in),
  .hwdata_in     (hwdata_in),
  .hready_in     (hready_in),
  .hreadyout_out (hreadyout_out),
  .hresp_out     (hresp_out),
  .timer_out     (timer_out),
  .timer_irq_out (timer_irq_out)
);

// ===== verif/stmr_timer_tb.sv
// testbench: bus, pwm, single pulse and capture runs of the standard timer
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module stmr_timer_tb
  import stmr_pkg::*;
;
  localparam int         LIMIT = 30000;  // run ceiling in cycles
  localparam logic [7:0] OFF_NONE = 8'h14; // nothing mapped here
  logic        clk_in, rst_in, hsel, hwrite, hrdy, hresp, tout, tirq, trig, cap, ovp, prev_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, cyc, ones, rises, irqs, stamp, rdat;
  int          miscompares, num_checks;
  // pwm table: swap, polarity, clear select, p code, a value, pin field
  int t_sw[8] = '{0, 0, 1, 0, 0, 0, 0, 0};
  int t_pl[8] = '{0, 1, 0, 0, 0, 1, 0, 0};
  int t_cl[8] = '{0, 1, 0, 0, 1, 0, 0, 0};
  int t_p[8]  = '{1, 2, 1, 1, 0, 1, 1, 1};
  int t_a[8]  = '{0, 100, 299, 200, 100, 0, 50, 50};
  int t_pn[8] = '{2, 2, 2, 2, 2, 2, 0, 1};
  int cap_n[4] = '{1, 1, 2, 0};  // captures per pulse for each edge setting

  stmr_timer dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .external_trigger_pin_in(trig), .capture_input_pin_in(cap),
    .overvoltage_event_in(ovp), .timer_out(tout), .timer_irq_out(tirq));
  stmr_pins pins (.clk_in(clk_in), .trig_out(trig), .cap_out(cap), .ovp_out(ovp));

  // ==========================================================
  // clock
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // pin monitors and the hang guard
  always @(posedge clk_in)
  begin
    cyc    <= cyc + 1;
    ones   <= ones + {31'h0, tout === 1'b1};
    rises  <= rises + {31'h0, tout === 1'b1 && prev_q === 1'b0};
    irqs   <= irqs + {31'h0, tirq === 1'b1};
    prev_q <= tout;
    if (cyc == LIMIT)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    stamp = cyc;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, STMR_ZERO32);
  endtask

  // control word with the initial level always high
  function automatic logic [31:0] ctl(input int md, pn, pl, sw, cl, cs, rn);
    ctl = 32'(rn) | 32'(md) << STMR_CTL_MODE_LO | 32'(pn) << STMR_CTL_PIN_LO
      | 32'h1 << STMR_CTL_INIT | 32'(pl) << STMR_CTL_POL | 32'(sw) << STMR_CTL_SWAP
      | 32'(cl) << STMR_CTL_CLRSEL | 32'(cs) << STMR_CTL_CAPSRC;
  endfunction

  // ==========================================================
  // main sequence
  initial
  begin
    int          per, dty, high, a1, a2, d, i;
    logic [31:0] o0, r0, i0, w1, c1, s1;
    {rst_in, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b1, 4'h0, 3'b010, 64'h0};
    {cyc, ones, rises, irqs, prev_q, miscompares, num_checks} = '0;
    void'($urandom(54504));
    tick(8);
    rst_in <= 1'b0;
    // reset values, read only counter, unmapped hole
    for (i = 0; i < 6; i++)
    begin
      rd(8'(4 * i));
      `CHK("reset value", STMR_ZERO32, rdat)
    end
    wr(STMR_OFF_CMPA, 32'hFFFF_FFFF);
    wr(STMR_OFF_COUNT, 32'h0000_0155);
    wr(OFF_NONE, $urandom);
    rd(STMR_OFF_CMPA);
    `CHK("cmpa width", 32'h0000_03FF, rdat)
    rd(STMR_OFF_COUNT);
    `CHK("count read only", STMR_ZERO32, rdat)
    rd(OFF_NONE);
    `CHK("unmapped", STMR_ZERO32, rdat)
    // pwm: high cycles over two periods from the model
    t_a[0] = 1 + $urandom % 120;
    for (i = 0; i < 8; i++)
    begin
      per  = t_sw[i] ? t_a[i] + 1 : (t_p[i] == 0 ? 1024 : t_p[i] * 128);
      dty  = t_sw[i] ? (t_p[i] == 0 ? 1024 : t_p[i] * 128) : t_a[i];
      high = dty >= per ? per : dty;
      high = t_pl[i] ? per - high : high;
      high = t_pn[i] == 0 ? 0 : (t_pn[i] == 1 ? per : high);
      wr(STMR_OFF_CTRL, STMR_ZERO32);
      wr(STMR_OFF_CMPA, 32'(t_a[i]));
      wr(STMR_OFF_CMPP, 32'(t_p[i]));
      wr(STMR_OFF_CTRL, ctl(2, t_pn[i], t_pl[i], t_sw[i], t_cl[i], 0, 1));
      tick(per + 10);
      o0 = ones;
      r0 = rises;
      tick(2 * per);
      `CHK("pwm high", 32'(2 * high), ones - o0)
      `CHK("pwm rises", 32'((high > 0 && high < per) ? 2 : 0), rises - r0)
    end
    // single pulse by software, then by trigger with a longer width
    a1 = 20 + $urandom % 100;
    a2 = a1 + 1 + $urandom % 60;
    wr(STMR_OFF_CTRL, ctl(2, 3, 0, 0, 0, 0, 0));
    wr(STMR_OFF_CMPA, 32'(a1));
    o0 = ones;
    i0 = irqs;
    wr(STMR_OFF_CTRL, ctl(2, 3, 0, 0, 0, 0, 1));
    tick(300);
    w1 = ones - o0;
    `CHK("pulse width", 32'(a1 + 1), w1)
    `CHK("pulse irq", i0 + 1, irqs)
    rd(STMR_OFF_COUNT);
    c1 = rdat;
    tick(20);
    rd(STMR_OFF_COUNT);
    `CHK("count after pulse", c1, rdat)
    wr(STMR_OFF_CTRL, ctl(2, 3, 0, 1, 1, 0, 0) | 32'h1 << STMR_CTL_TRIG_POL);
    wr(STMR_OFF_CMPP, 32'h5);
    wr(STMR_OFF_CMPA, 32'(a2));
    o0 = ones;
    i0 = irqs;
    pins.pulse(0, 4);
    tick(300);
    `CHK("pulse width step", 32'(a2 - a1), ones - o0 - w1)
    `CHK("trigger irq", i0 + 1, irqs)
    // capture edge settings, output settings set but ignored
    for (i = 0; i < 4; i++)
    begin
      d = 100 + $urandom % 100;
      wr(STMR_OFF_CTRL, STMR_ZERO32);
      wr(STMR_OFF_CMPP, STMR_ZERO32);
      wr(STMR_OFF_CTRL, ctl(1, i, 1, 1, 1, 0, 1));
      i0 = irqs;
      fork
        pins.pulse(1, d);
        begin
          tick(12);
          rd(STMR_OFF_CMPA);
          c1 = rdat;
        end
      join
      tick(12);
      rd(STMR_OFF_CMPA);
      `CHK("capture irqs", i0 + 32'(cap_n[i]), irqs)
      if (i == 2)
        `CHK("capture spacing", 32'(d), rdat - c1)
    end
    // overvoltage event as capture source
    wr(STMR_OFF_CTRL, STMR_ZERO32);
    wr(STMR_OFF_CTRL, ctl(1, 0, 0, 0, 0, 1, 1));
    i0 = irqs;
    pins.pulse(1, 50);
    tick(10);
    `CHK("pin ignored", i0, irqs)
    pins.pulse(2, 50);
    tick(10);
    `CHK("overvoltage capture", i0 + 1, irqs)
    // p match bounds the count; edges off with pin 11
    wr(STMR_OFF_CTRL, STMR_ZERO32);
    wr(STMR_OFF_CMPP, 32'h1);
    wr(STMR_OFF_CTRL, ctl(1, 3, 0, 0, 0, 0, 1));
    i0 = irqs;
    pins.pulse(1, 30);
    tick(370);
    `CHK("p match irqs", i0 + 3, irqs)
    // p zero: full wrap, one count per clock
    wr(STMR_OFF_CTRL, STMR_ZERO32);
    wr(STMR_OFF_CMPP, STMR_ZERO32);
    wr(STMR_OFF_CTRL, ctl(1, 3, 0, 0, 0, 0, 1));
    tick(400);
    rd(STMR_OFF_COUNT);
    c1 = rdat;
    s1 = stamp;
    tick(700);
    rd(STMR_OFF_COUNT);
    `CHK("free count", (c1 + stamp - s1) % 1024, rdat)
    wrap_up();
  end
endmodule

// ===== verilog/stmr_pkg.sv
// package: register map, field layout and encodings for the standard timer block
package stmr_pkg;

  // ==========================================================
  // bus register byte offsets
  localparam logic [7:0] STMR_OFF_CTRL   = 8'h00;  // control word
  localparam logic [7:0] STMR_OFF_CMPA   = 8'h04;  // compare_a_value
  localparam logic [7:0] STMR_OFF_CMPP   = 8'h08;  // compare_p_value (3 bits)
  localparam logic [7:0] STMR_OFF_COUNT  = 8'h0C;  // live counter, read only
  localparam logic [7:0] STMR_OFF_STATUS = 8'h10;  // event flags, write one to clear

  // ==========================================================
  // control word field positions
  localparam int STMR_CTL_RUN      = 0;   // counter_run_bit
  localparam int STMR_CTL_MODE_LO  = 1;   // mode_select_low
  localparam int STMR_CTL_MODE_HI  = 2;   // mode_select_high
  localparam int STMR_CTL_PIN_LO   = 3;   // pin_control_low
  localparam int STMR_CTL_PIN_HI   = 4;   // pin_control_high
  localparam int STMR_CTL_INIT     = 5;   // output_initial_level
  localparam int STMR_CTL_POL      = 6;   // output_polarity_invert
  localparam int STMR_CTL_SWAP     = 7;   // duty_period_swap
  localparam int STMR_CTL_CLRSEL   = 8;   // clear_source_select
  localparam int STMR_CTL_CAPSRC   = 9;   // capture source: 0 pin, 1 overvoltage_event
  localparam int STMR_CTL_TRIG_POL = 10;  // trigger active edge: 0 rising, 1 falling

  // status flag positions
  localparam int STMR_ST_AMATCH = 0;  // compare a match or capture
  localparam int STMR_ST_PMATCH = 1;  // compare p match
  localparam int STMR_ST_IRQ    = 2;  // live interrupt request level

  // ==========================================================
  // widths and constants
  localparam int           STMR_CNT_W     = 10;
  localparam logic [9:0]   STMR_CNT_MAX   = 10'h3FF;
  localparam logic [9:0]   STMR_CNT_ZERO  = 10'h000;
  localparam logic [2:0]   STMR_P_ZERO    = 3'h0;
  localparam int           STMR_P_SHIFT   = 7;       // code times 128
  localparam logic [10:0]  STMR_P_FULL    = 11'h400; // code 000b means 1024
  localparam logic [31:0]  STMR_CTL_RST   = 32'h0000_0000;
  localparam logic [31:0]  STMR_ZERO32    = 32'h0000_0000;

  // ==========================================================
  // encodings
  typedef enum logic [1:0]
  {
    STMR_MODE_CMP  = 2'b00,
    STMR_MODE_CAP  = 2'b01,
    STMR_MODE_PWM  = 2'b10,
    STMR_MODE_TMR  = 2'b11
  } stmr_mode_e;

  typedef enum logic [1:0]
  {
    STMR_PIN_00 = 2'b00,
    STMR_PIN_01 = 2'b01,
    STMR_PIN_10 = 2'b10,
    STMR_PIN_11 = 2'b11
  } stmr_pin_e;

  // decoded control settings that travel together
  typedef struct packed
  {
    logic       trig_pol;
    logic       cap_src;
    logic       clr_sel;
    logic       swap;
    logic       pol;
    logic       init;
    stmr_pin_e  pin;
    stmr_mode_e mode;
    logic       run;
  } stmr_ctl_s;

endpackage

// ===== verilog/stmr_sync.sv
// two-flop synchroniser with an edge pulse pair for external pins
`timescale 1ns/100ps
module stmr_sync
  import stmr_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // asynchronous pin
  input  wire logic pin_in,
  // synchronised level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  // ==========================================================
  // synchroniser and history
  logic meta_q;  // first stage, read only by the second
  logic sync_q;  // second stage
  logic prev_q;  // previous synchronised level

  // first stage feeds only the second; edges come off later stages
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;

endmodule

// ===== verilog/stmr_timer.sv
// top: 10-bit standard timer with pwm, single pulse and capture modes on ahb-lite
// ==========================================================
// Overview of operation
// - swap set: period from a, duty p*128
// - pwm clears on p match, or a if swapped
// - pwm counting continues while pin forced
// - clear source select ignored in pwm
// - run rising edge starts pulse immediately
// - trigger pin edge sets run bit
// - a match clears run, ending pulse
// - pulse-ending a match raises interrupt
// - pulse counter zeroed only at run rise
// - pulse mode ignores p, clear, swap
// - pin field picks capture edge, 11 off
// - capture edge copies counter into a
// - capture counter free-runs until run falls
// - capture p match zeroes counter, interrupts
// - capture p zero lets counter wrap full
// - capture ignores output and clear settings
// - capture input fed from overvoltage event
// - pwm duty at least period gives full
// - polarity invert flips pwm output
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
module stmr_timer
  import stmr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // external pins and events
  input  wire logic        external_trigger_pin_in,
  input  wire logic        capture_input_pin_in,
  input  wire logic        overvoltage_event_in,
  // timer output and interrupt request
  output logic             timer_out,
  output logic             timer_irq_out
);

  // ==========================================================
  // state
  logic [31:0]            ctl_q;        // control word
  logic [STMR_CNT_W-1:0]  cmpa_q;       // compare_a_value
  logic [2:0]             cmpp_q;       // compare_p_value
  logic [STMR_CNT_W-1:0]  cnt_q;        // the counter
  logic                   run_prev_q;   // run bit one cycle ago
  logic [1:0]             flags_q;      // sticky status flags
  logic                   out_q;        // raw waveform level
  logic                   pin_q;        // timer_out register
  logic                   irq_q;        // interrupt pulse register
  logic                   cap_prev_q;   // capture source history
  logic                   wr_pend_q;    // data phase of a write pending
  logic [7:0]             wr_addr_q;    // latched write offset
  logic [31:0]            rdata_q;      // read data register

  // ==========================================================
  // helpers
  // compare_p_value code scaled to counts; code zero means 1024
  function automatic logic [10:0] p_scaled(input logic [2:0] code);
    p_scaled = (code == STMR_P_ZERO) ? STMR_P_FULL : {1'b0, code, 7'h00};
  endfunction

  // ==========================================================
  // pin synchronisers
  logic trig_lvl;   // synchronised trigger pin
  logic trig_rise;  // trigger rising edge
  logic trig_fall;  // trigger falling edge
  logic cpin_lvl;   // synchronised capture pin
  logic ovp_lvl;    // synchronised overvoltage event

  stmr_sync u_trig
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (external_trigger_pin_in),
    .level_out (trig_lvl),
    .rise_out  (trig_rise),
    .fall_out  (trig_fall)
  );

  stmr_sync u_cpin
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (capture_input_pin_in),
    .level_out (cpin_lvl),
    .rise_out  (),
    .fall_out  ()
  );

  stmr_sync u_ovp
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (overvoltage_event_in),
    .level_out (ovp_lvl),
    .rise_out  (),
    .fall_out  ()
  );

  // ==========================================================
  // control decode
  stmr_ctl_s ctl;
  assign ctl.run      = ctl_q[STMR_CTL_RUN];
  assign ctl.mode     = stmr_mode_e'({ctl_q[STMR_CTL_MODE_HI], ctl_q[STMR_CTL_MODE_LO]});
  assign ctl.pin      = stmr_pin_e'({ctl_q[STMR_CTL_PIN_HI], ctl_q[STMR_CTL_PIN_LO]});
  assign ctl.init     = ctl_q[STMR_CTL_INIT];
  assign ctl.pol      = ctl_q[STMR_CTL_POL];
  assign ctl.swap     = ctl_q[STMR_CTL_SWAP];
  assign ctl.clr_sel  = ctl_q[STMR_CTL_CLRSEL];
  assign ctl.cap_src  = ctl_q[STMR_CTL_CAPSRC];
  assign ctl.trig_pol = ctl_q[STMR_CTL_TRIG_POL];

  wire is_pwm   = (ctl.mode == STMR_MODE_PWM) & (ctl.pin != STMR_PIN_11);
  wire is_pulse = (ctl.mode == STMR_MODE_PWM) & (ctl.pin == STMR_PIN_11);
  wire is_cap   = (ctl.mode == STMR_MODE_CAP);
  wire is_cmp   = (ctl.mode == STMR_MODE_CMP) | (ctl.mode == STMR_MODE_TMR);

  wire run_rise = ctl.run & ~run_prev_q;

  // ==========================================================
  // compare matches, evaluated on every count
  wire [10:0] cnt_ext  = {1'b0, cnt_q};
  wire [10:0] cmpa_ext = {1'b0, cmpa_q};
  wire [10:0] p_cnt    = p_scaled(cmpp_q);
  wire [10:0] cnt_next = cnt_ext + 11'h001;

  // p compares on the count reaching its scaled value; 1024 hits on wrap
  wire p_match   = ctl.run & (cnt_next == p_cnt);
  wire a_match   = ctl.run & (cnt_q == cmpa_q);
  // pwm period and duty sources
  wire [10:0] period = ctl.swap ? (cmpa_ext + 11'h001) : p_cnt;
  wire [10:0] duty   = ctl.swap ? p_cnt : cmpa_ext;
  // pwm end of period: clear source follows swap, clear select ignored
  wire pwm_clr = ctl.swap ? a_match : p_match;
  // capture clears on p match unless p is zero, then wraps full
  wire cap_clr = p_match & (cmpp_q != STMR_P_ZERO);
  // compare/timer modes honour clear_source_select
  wire cmp_clr = ctl.clr_sel ? a_match : p_match;

  // ==========================================================
  // capture source and edge select
  wire cap_lvl  = ctl.cap_src ? ovp_lvl : cpin_lvl;
  wire cap_rise = cap_lvl & ~cap_prev_q;
  wire cap_fall = ~cap_lvl & cap_prev_q;
  wire cap_edge = is_cap & ctl.run & (((ctl.pin == STMR_PIN_00) & cap_rise) |
                  ((ctl.pin == STMR_PIN_01) & cap_fall) |
                  ((ctl.pin == STMR_PIN_10) & (cap_rise | cap_fall)));

  // trigger pin sets run in pulse mode
  wire trig_edge = is_pulse & (ctl.trig_pol ? trig_fall : trig_rise);
  // a match ends the pulse by clearing run
  wire pulse_end = is_pulse & a_match & ~run_rise;

  // ==========================================================
  // bus decode
  wire        bus_go   = hsel_in & hready_in & htrans_in[1];
  wire        bus_wr   = bus_go & hwrite_in;
  wire        bus_rd   = bus_go & ~hwrite_in;
  wire [7:0]  rd_off   = haddr_in[7:0];
  wire        wr_ctl   = wr_pend_q & (wr_addr_q == STMR_OFF_CTRL);
  wire        wr_cmpa  = wr_pend_q & (wr_addr_q == STMR_OFF_CMPA);
  wire        wr_cmpp  = wr_pend_q & (wr_addr_q == STMR_OFF_CMPP);
  wire        wr_stat  = wr_pend_q & (wr_addr_q == STMR_OFF_STATUS);

  // read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
    (rd_off == STMR_OFF_CTRL)   ? ctl_q :
    (rd_off == STMR_OFF_CMPA)   ? {22'h0, cmpa_q} :
    (rd_off == STMR_OFF_CMPP)   ? {29'h0, cmpp_q} :
    (rd_off == STMR_OFF_COUNT)  ? {22'h0, cnt_q} :
    (rd_off == STMR_OFF_STATUS) ? {29'h0, irq_q, flags_q} : STMR_ZERO32;

  // ==========================================================
  // next control word: software write, then hardware run edits
  logic [31:0] ctl_d;
  always_comb
  begin
    ctl_d = wr_ctl ? hwdata_in : ctl_q;
    // hardware set beats a same-cycle software clear
    if (trig_edge)
      ctl_d[STMR_CTL_RUN] = 1'b1;
    else if (pulse_end)
      ctl_d[STMR_CTL_RUN] = 1'b0;
  end

  // ==========================================================
  // counter next value
  logic [STMR_CNT_W-1:0] cnt_d;
  always_comb
  begin
    if (run_rise)
      cnt_d = STMR_CNT_ZERO;
    else if (!ctl.run)
      cnt_d = cnt_q;                      // held while stopped
    else if (is_pwm)
      cnt_d = pwm_clr ? STMR_CNT_ZERO : cnt_next[9:0];
    else if (is_pulse)
      cnt_d = pulse_end ? cnt_q : cnt_next[9:0];
    else if (is_cap)
      cnt_d = cap_clr ? STMR_CNT_ZERO : cnt_next[9:0];
    else
      cnt_d = cmp_clr ? STMR_CNT_ZERO : cnt_next[9:0];
  end

  // ==========================================================
  // output waveform, before pin forcing and polarity
  logic out_d;
  always_comb
  begin
    if (is_pwm)
      // active while counter below duty, full when duty reaches period
      out_d = (duty >= period) | (cnt_ext < duty) ? ctl.init : ~ctl.init;
    else if (is_pulse)
      out_d = (ctl.run & ~pulse_end) ? ctl.init : ~ctl.init;
    else if (is_cmp)
      out_d = run_rise ? ctl.init : (a_match ? ~out_q : out_q);
    else
      out_d = out_q;                        // capture has no output
  end

  // pin level: forced levels for 00/01 in pwm, low in capture, polarity invert otherwise
  logic pin_d;
  always_comb
  begin
    if (is_pwm & (ctl.pin == STMR_PIN_00))
      pin_d = 1'b0;
    else if (is_pwm & (ctl.pin == STMR_PIN_01))
      pin_d = 1'b1;
    else if (is_cap)
      pin_d = 1'b0;
    else
      pin_d = out_d ^ ctl.pol;
  end

  // interrupt events per mode
  wire ev_a = is_cap ? cap_edge : (is_pulse ? pulse_end : (ctl.run & a_match));
  wire ev_p = (is_cap | is_pwm | is_cmp) & p_match;

  // ==========================================================
  // control, counter and waveform registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctl_q      <= STMR_CTL_RST;
      cnt_q      <= STMR_CNT_ZERO;
      run_prev_q <= 1'b0;
      out_q      <= 1'b0;
      pin_q      <= 1'b0;
      cap_prev_q <= 1'b0;
    end
    else
    begin
      ctl_q      <= ctl_d;
      cnt_q      <= cnt_d;
      run_prev_q <= ctl.run;
      out_q      <= out_d;
      pin_q      <= pin_d;
      cap_prev_q <= cap_lvl;
    end
  end

  // ==========================================================
  // compare values: capture overwrites a, winning over software
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cmpa_q <= STMR_CNT_ZERO;
      cmpp_q <= STMR_P_ZERO;
    end
    else
    begin
      if (cap_edge)
        cmpa_q <= cnt_q;
      else if (wr_cmpa)
        cmpa_q <= hwdata_in[9:0];
      if (wr_cmpp)
        cmpp_q <= hwdata_in[2:0];
    end
  end

  // ==========================================================
  // status flags, set wins over write-one-to-clear; irq one-cycle pulse
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      flags_q <= 2'b00;
      irq_q   <= 1'b0;
    end
    else
    begin
      flags_q <= ({ev_p, ev_a}) |
                 (flags_q & ~(wr_stat ? hwdata_in[1:0] : 2'b00));
      irq_q   <= ev_a | ev_p;
    end
  end

  // ==========================================================
  // ahb-lite slave: zero wait, okay always
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= STMR_ZERO32;
    end
    else
    begin
      wr_pend_q <= bus_wr;
      wr_addr_q <= haddr_in[7:0];
      rdata_q   <= bus_rd ? rd_mux : rdata_q;
    end
  end

  assign hrdata_out    = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign timer_out     = pin_q;
  assign timer_irq_out = irq_q;

endmodule
